// ===== logic/ddr_init_pkg.sv
// constants, command codes and pin bundle for the ddr power-up controller
package ddr_init_pkg;
  // ==========================================================================
  // clocking
  localparam int CORE_PERIOD_PS = 5000;
  localparam int DRAM_CLK_DIV = 2;
  localparam int WAIT_W = 17;
  // ==========================================================================
  // sequence timing, least times rounded up to whole core cycles
  localparam int POWERUP_WAIT_US = 200;
  localparam int POWERUP_CYC =
    (POWERUP_WAIT_US * 1000000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
  localparam int ROW_PRECHARGE_TIME_NS = 20;
  localparam int ROW_PRECHARGE_CYC =
    (ROW_PRECHARGE_TIME_NS * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
  localparam int MODE_REGISTER_SET_TIME_NS = 15;
  localparam int MODE_REGISTER_SET_CYC =
    (MODE_REGISTER_SET_TIME_NS * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
  localparam int REFRESH_CYCLE_TIME_NS = 75;
  localparam int REFRESH_CYCLE_CYC =
    (REFRESH_CYCLE_TIME_NS * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
  localparam int DLL_LOCK_DRAM_CYC = 200;
  localparam int DLL_LOCK_CYC = DLL_LOCK_DRAM_CYC * DRAM_CLK_DIV;
  // longest refresh spacing, rounded down
  localparam int REFRESH_PERIOD_SMALL_NS = 140600;
  localparam int REFRESH_PERIOD_LARGE_NS = 70300;
  localparam int REFRESH_SMALL_CYC = REFRESH_PERIOD_SMALL_NS * 1000 / CORE_PERIOD_PS;
  localparam int REFRESH_LARGE_CYC = REFRESH_PERIOD_LARGE_NS * 1000 / CORE_PERIOD_PS;
  // covers a relock and an alignment tick between a due refresh and its issue
  localparam int REFRESH_SLACK_CYC = 64;
  localparam int REFRESH_POST_MAX = 8;
  localparam int REFRESH_DEBT_W = 4;
  // ==========================================================================
  // commands, op = {cs_n, ras_n, cas_n, we_n}
  localparam int ADDR_W = 13;
  localparam logic [3:0] OP_NOP = 4'h7;
  localparam logic [3:0] OP_PRE = 4'h2;
  localparam logic [3:0] OP_REF = 4'h1;
  localparam logic [3:0] OP_LMR = 4'h0;
  localparam logic [1:0] BA_BASE = 2'h0;
  localparam logic [1:0] BA_EXT = 2'h1;
  localparam logic [ADDR_W-1:0] PRE_ALL_MASK = 13'h0400;
  localparam logic [ADDR_W-1:0] BASE_DLL_RESET_MASK = 13'h0100;
  localparam logic [ADDR_W-1:0] EXT_DLL_DISABLE_MASK = 13'h0001;
  localparam logic [ADDR_W-1:0] EXT_DRIVE_STRENGTH_MASK = 13'h0002;
  typedef struct packed {
    logic [3:0] op;
    logic [1:0] ba;
    logic [ADDR_W-1:0] addr;
  } dram_cmd_t;
  localparam dram_cmd_t NOP_CMD = '{op: OP_NOP, ba: BA_BASE, addr: 13'h0000};
  // ==========================================================================
  // software registers
  localparam int WB_ADR_W = 8;
  localparam logic [7:0] REG_CTRL_OFS = 8'h00;
  localparam logic [7:0] REG_MODE_OFS = 8'h04;
  localparam logic [7:0] REG_STATUS_OFS = 8'h08;
  localparam int CTRL_W = 5;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_REDUCED_DRIVE_BIT = 1;
  localparam int CTRL_FINAL_LMR_BIT = 2;
  localparam int CTRL_RELOCK_BIT = 3;
  localparam int CTRL_SMALL_DENSITY_BIT = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h04;
  localparam logic [ADDR_W-1:0] MODE_RESET = 13'h0000;
  localparam int ST_DONE_BIT = 0;
  localparam int ST_READ_OK_BIT = 1;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_DEBT_LSB = 4;
endpackage

// ===== logic/wait_timer.sv
// down counter that times one wait of the init sequence
`timescale 1ns/1ps
`default_nettype none
module wait_timer #(
  parameter int W = 17
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // control
  input wire logic load_in,
  input wire logic [W-1:0] len_in,
  output logic done_out
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q <= '0;
    end else if (ce_in) begin
      if (load_in) begin
        cnt_q <= len_in;
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  assign done_out = (cnt_q == '0);
endmodule
`default_nettype wire

// ===== logic/refresh_pacer.sv
// paces periodic refreshes and counts the ones still owed
`timescale 1ns/1ps
`default_nettype none
module refresh_pacer
  import ddr_init_pkg::*;
#(
  parameter int W = 17
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // control
  input wire logic en_in,
  input wire logic [W-1:0] interval_in,
  input wire logic take_in,
  output logic due_out,
  output logic [REFRESH_DEBT_W-1:0] debt_out
);
  logic [W-1:0] cnt_q;
  logic owe;

  assign owe = en_in && (cnt_q >= interval_in - 1'b1);

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q <= '0;
    end else if (ce_in) begin
      cnt_q <= (!en_in || owe) ? '0 : cnt_q + 1'b1;
    end
  end

  // the debt saturates: more than the post limit is never kept
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      debt_out <= '0;
    end else if (ce_in) begin
      if (owe && !take_in && debt_out != REFRESH_DEBT_W'(REFRESH_POST_MAX)) begin
        debt_out <= debt_out + 1'b1;
      end else if (take_in && !owe && debt_out != '0) begin
        debt_out <= debt_out - 1'b1;
      end
    end
  end

  assign due_out = (debt_out != '0);
endmodule
`default_nettype wire

// ===== logic/ddr_init_ctrl.sv
// ddr power-up sequencer and refresh keeper with a wishbone register slave
// How it works
// - after power, hold clock-enable low with a running clock for 200 us
// - then raise clock-enable together with at least one NOP
// - first command is precharge-all, then only NOPs for row precharge time
// - load extended mode: DLL enable bit zero, drive bit selectable, rest zero
// - after each mode load only NOPs for the mode-register-set time
// - then load the base mode with operating values and DLL reset
// - at least 200 DRAM clocks from DLL reset to any read
// - second precharge-all after base load, NOPs for row precharge time
// - two auto refreshes, each followed by refresh cycle time of NOPs
// - optional final base load clearing DLL reset, same values, then wait
// - clock-enable stays high from refresh issue until refresh time ends
// - after a clock frequency change reset the DLL and wait 200 clocks
// - row active time between 40 ns and 120000 ns
// - refresh at least every 140.6 or 70.3 us, never over eight owed
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module ddr_init_ctrl
  import ddr_init_pkg::*;
#(
  parameter int POWERUP_WAIT_CYC = POWERUP_CYC,
  parameter int REF_SMALL_CYC = REFRESH_SMALL_CYC,
  parameter int REF_LARGE_CYC = REFRESH_LARGE_CYC
) (
  // clock, reset, enable
  input wire logic CORE_CLK_IN,
  input wire logic NRST_IN,
  input wire logic CE_IN,
  // wishbone slave
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [WB_ADR_W-1:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  // memory pins
  output logic DRAM_CK_OUT,
  output logic DRAM_CK_N_OUT,
  output logic DRAM_CKE_OUT,
  output var dram_cmd_t DRAM_CMD_OUT,
  // status
  output logic INIT_DONE_OUT,
  output logic READ_OK_OUT
);
  // ==========================================================================
  // types and lengths
  typedef enum logic [10:0] {
    S_RESET = 11'h001,
    S_HOLD  = 11'h002,
    S_PRE1  = 11'h004,
    S_EMR   = 11'h008,
    S_MRDLL = 11'h010,
    S_PRE2  = 11'h020,
    S_REF1  = 11'h040,
    S_REF2  = 11'h080,
    S_MRCLR = 11'h100,
    S_WAIT  = 11'h200,
    S_READY = 11'h400
  } state_t;

  localparam logic [WAIT_W-1:0] PWR_LEN = WAIT_W'(POWERUP_WAIT_CYC);
  localparam logic [WAIT_W-1:0] TRP_LEN = WAIT_W'(ROW_PRECHARGE_CYC);
  localparam logic [WAIT_W-1:0] MODE_REGISTER_SET_TIME_LEN = WAIT_W'(MODE_REGISTER_SET_CYC);
  localparam logic [WAIT_W-1:0] REFRESH_CYCLE_TIME_LEN = WAIT_W'(REFRESH_CYCLE_CYC);
  localparam logic [WAIT_W-1:0] DLL_LEN = WAIT_W'(DLL_LOCK_CYC);
  localparam logic [WAIT_W-1:0] REF_SMALL_LEN = WAIT_W'(REF_SMALL_CYC - REFRESH_SLACK_CYC);
  localparam logic [WAIT_W-1:0] REF_LARGE_LEN = WAIT_W'(REF_LARGE_CYC - REFRESH_SLACK_CYC);

  state_t state_q, ret_q, goto, nxt_ret;
  dram_cmd_t cmd_q, nxt_cmd;
  logic ck_q, ck_n_q, cke_q, cke_d, done_q, read_ok_q, ack_q;
  logic load_q, dll_load_q, cmd_new_q, wait_go, dll_rst;
  logic seq_done, dll_done, ref_due, ref_take, relock_take;
  logic [WAIT_W-1:0] len_q, nxt_len;
  logic [CTRL_W-1:0] ctrl_q;
  logic [ADDR_W-1:0] mode_q;
  logic [REFRESH_DEBT_W-1:0] debt;
  logic [31:0] dat_q, rd_data;
  logic wb_req, wb_wr;

  // ==========================================================================
  // dram clock: half the core rate, commands change on its falling edge
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ck_q <= 1'b0;
      ck_n_q <= 1'b1;
    end else if (CE_IN) begin
      ck_q <= ~ck_q;
      ck_n_q <= ck_q;
    end
  end

  // ==========================================================================
  // sequencer decisions, taken once per dram clock while ck is high
  always_comb begin
    goto = state_q;
    nxt_ret = ret_q;
    nxt_cmd = NOP_CMD;
    nxt_len = '0;
    wait_go = 1'b0;
    cke_d = cke_q;
    dll_rst = 1'b0;
    ref_take = 1'b0;
    relock_take = 1'b0;
    case (state_q)
      S_RESET: begin
        nxt_len = PWR_LEN;
        nxt_ret = S_HOLD;
        wait_go = 1'b1;
      end
      S_HOLD: if (ctrl_q[CTRL_START_BIT]) begin
        cke_d = 1'b1;
        goto = S_PRE1;
      end
      S_PRE1: begin
        nxt_cmd = '{op: OP_PRE, ba: BA_BASE, addr: PRE_ALL_MASK};
        nxt_len = TRP_LEN;
        nxt_ret = S_EMR;
        wait_go = 1'b1;
      end
      S_EMR: begin
        nxt_cmd.op = OP_LMR;
        nxt_cmd.ba = BA_EXT;
        nxt_cmd.addr = ctrl_q[CTRL_REDUCED_DRIVE_BIT] ? EXT_DRIVE_STRENGTH_MASK : '0;
        nxt_len = MODE_REGISTER_SET_TIME_LEN;
        nxt_ret = S_MRDLL;
        wait_go = 1'b1;
      end
      S_MRDLL: begin
        nxt_cmd = '{op: OP_LMR, ba: BA_BASE, addr: mode_q | BASE_DLL_RESET_MASK};
        nxt_len = MODE_REGISTER_SET_TIME_LEN;
        nxt_ret = S_PRE2;
        wait_go = 1'b1;
        dll_rst = 1'b1;
      end
      S_PRE2: begin
        nxt_cmd = '{op: OP_PRE, ba: BA_BASE, addr: PRE_ALL_MASK};
        nxt_len = TRP_LEN;
        nxt_ret = S_REF1;
        wait_go = 1'b1;
      end
      S_REF1: begin
        nxt_cmd = '{op: OP_REF, ba: BA_BASE, addr: 13'h0000};
        nxt_len = REFRESH_CYCLE_TIME_LEN;
        nxt_ret = S_REF2;
        wait_go = 1'b1;
      end
      S_REF2: begin
        nxt_cmd = '{op: OP_REF, ba: BA_BASE, addr: 13'h0000};
        nxt_len = REFRESH_CYCLE_TIME_LEN;
        nxt_ret = ctrl_q[CTRL_FINAL_LMR_BIT] ? S_MRCLR : S_READY;
        wait_go = 1'b1;
      end
      S_MRCLR: begin
        nxt_cmd = '{op: OP_LMR, ba: BA_BASE, addr: mode_q & ~BASE_DLL_RESET_MASK};
        nxt_len = MODE_REGISTER_SET_TIME_LEN;
        nxt_ret = S_READY;
        wait_go = 1'b1;
      end
      S_WAIT: if (seq_done) begin
        goto = ret_q;
      end
      S_READY: begin
        // only precharge, refresh and mode loads are issued, no row is ever
        // opened, so the row-active window is never entered
        if (ref_due) begin
          nxt_cmd = '{op: OP_REF, ba: BA_BASE, addr: 13'h0000};
          nxt_len = REFRESH_CYCLE_TIME_LEN;
          nxt_ret = S_READY;
          wait_go = 1'b1;
          ref_take = 1'b1;
        end else if (ctrl_q[CTRL_RELOCK_BIT]) begin
          nxt_cmd = '{op: OP_LMR, ba: BA_BASE, addr: mode_q | BASE_DLL_RESET_MASK};
          nxt_len = MODE_REGISTER_SET_TIME_LEN;
          nxt_ret = ctrl_q[CTRL_FINAL_LMR_BIT] ? S_MRCLR : S_READY;
          wait_go = 1'b1;
          dll_rst = 1'b1;
          relock_take = 1'b1;
        end
      end
      default: goto = S_RESET;
    endcase
    if (wait_go) begin
      goto = S_WAIT;
    end
  end

  // ==========================================================================
  // sequencer state and pin registers
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state_q <= S_RESET;
      ret_q <= S_READY;
      cmd_q <= NOP_CMD;
      cke_q <= 1'b0;
      len_q <= '0;
      load_q <= 1'b0;
      dll_load_q <= 1'b0;
      cmd_new_q <= 1'b0;
    end else if (CE_IN) begin
      load_q <= 1'b0;
      dll_load_q <= 1'b0;
      cmd_new_q <= 1'b0;
      if (ck_q) begin
        state_q <= goto;
        ret_q <= nxt_ret;
        cmd_q <= nxt_cmd;
        cke_q <= cke_d;
        len_q <= nxt_len;
        load_q <= wait_go;
        dll_load_q <= dll_rst;
        cmd_new_q <= (nxt_cmd.op != OP_NOP);
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      done_q <= 1'b0;
      read_ok_q <= 1'b0;
    end else if (CE_IN) begin
      done_q <= done_q | (state_q == S_READY);
      read_ok_q <= !dll_load_q && done_q && dll_done;
    end
  end

  wait_timer #(.W(WAIT_W)) seq_timer (
    .clk_in(CORE_CLK_IN),
    .nrst_in(NRST_IN),
    .ce_in(CE_IN),
    .load_in(load_q),
    .len_in(len_q),
    .done_out(seq_done)
  );

  wait_timer #(.W(WAIT_W)) dll_timer (
    .clk_in(CORE_CLK_IN),
    .nrst_in(NRST_IN),
    .ce_in(CE_IN),
    .load_in(dll_load_q),
    .len_in(DLL_LEN),
    .done_out(dll_done)
  );

  refresh_pacer #(.W(WAIT_W)) pacer (
    .clk_in(CORE_CLK_IN),
    .nrst_in(NRST_IN),
    .ce_in(CE_IN),
    .en_in(done_q),
    .interval_in(ctrl_q[CTRL_SMALL_DENSITY_BIT] ? REF_SMALL_LEN : REF_LARGE_LEN),
    .take_in(ref_take && ck_q),
    .due_out(ref_due),
    .debt_out(debt)
  );

  // ==========================================================================
  // wishbone slave: one wait state, ack for one cycle, unmapped reads zero
  assign wb_req = WB_CYC_IN && WB_STB_IN && !ack_q;
  assign wb_wr = wb_req && WB_WE_IN;

  always_comb begin
    rd_data = '0;
    case (WB_ADR_IN)
      REG_CTRL_OFS: rd_data[CTRL_W-1:0] = ctrl_q;
      REG_MODE_OFS: rd_data[ADDR_W-1:0] = mode_q;
      REG_STATUS_OFS: begin
        rd_data[ST_DONE_BIT] = done_q;
        rd_data[ST_READ_OK_BIT] = read_ok_q;
        rd_data[ST_BUSY_BIT] = (state_q != S_READY);
        rd_data[ST_DEBT_LSB +: REFRESH_DEBT_W] = debt;
      end
      default: rd_data = '0;
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else if (CE_IN) begin
      ack_q <= wb_req;
      if (wb_req) begin
        dat_q <= WB_WE_IN ? 32'h0000_0000 : rd_data;
      end
    end
  end

  // a write in the same cycle as the hardware taking a relock keeps its value
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ctrl_q <= CTRL_RESET;
      mode_q <= MODE_RESET;
    end else if (CE_IN) begin
      if (relock_take && ck_q) begin
        ctrl_q[CTRL_RELOCK_BIT] <= 1'b0;
      end
      if (wb_wr && WB_ADR_IN == REG_CTRL_OFS && WB_SEL_IN[0]) begin
        ctrl_q <= WB_DAT_IN[CTRL_W-1:0];
      end
      if (wb_wr && WB_ADR_IN == REG_MODE_OFS) begin
        if (WB_SEL_IN[0]) begin
          mode_q[7:0] <= WB_DAT_IN[7:0];
        end
        if (WB_SEL_IN[1]) begin
          mode_q[ADDR_W-1:8] <= WB_DAT_IN[ADDR_W-1:8];
        end
      end
    end
  end

  assign WB_ACK_OUT = ack_q;
  assign WB_DAT_OUT = dat_q;
  assign DRAM_CK_OUT = ck_q;
  assign DRAM_CK_N_OUT = ck_n_q;
  assign DRAM_CKE_OUT = cke_q;
  assign DRAM_CMD_OUT = cmd_q;
  assign INIT_DONE_OUT = done_q;
  assign READ_OK_OUT = read_ok_q;

  // ==========================================================================
  // checks and the helper counters they read
  logic [WAIT_W-1:0] up_q, gap_q, dll_gap_q, ref_gap_q;
  logic [3:0] last_op_q;
  logic [1:0] ref_cnt_q;
  logic emr_seen_q;

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      up_q <= '0;
      gap_q <= '0;
      dll_gap_q <= '0;
      ref_gap_q <= '0;
      last_op_q <= OP_NOP;
      ref_cnt_q <= '0;
      emr_seen_q <= 1'b0;
    end else if (CE_IN) begin
      if (!(&up_q)) up_q <= up_q + 1'b1;
      if (!(&gap_q)) gap_q <= gap_q + 1'b1;
      if (!(&dll_gap_q)) dll_gap_q <= dll_gap_q + 1'b1;
      if (!(&ref_gap_q)) ref_gap_q <= ref_gap_q + 1'b1;
      if (cmd_new_q) begin
        gap_q <= WAIT_W'(1);
        last_op_q <= cmd_q.op;
        if (cmd_q.op == OP_REF) begin
          ref_gap_q <= WAIT_W'(1);
          if (ref_cnt_q != 2'h3) ref_cnt_q <= ref_cnt_q + 1'b1;
        end
        if (cmd_q.op == OP_LMR && cmd_q.ba == BA_EXT) emr_seen_q <= 1'b1;
        if (cmd_q.op == OP_LMR && (cmd_q.addr & BASE_DLL_RESET_MASK) != '0) begin
          dll_gap_q <= WAIT_W'(1);
        end
      end
    end
  end

  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!NRST_IN);

  sequence s_nop_tick;
    (cmd_q.op == OP_NOP) [*2];
  endsequence
  sequence s_dll_load;
    cmd_new_q && cmd_q.op == OP_LMR && cmd_q.ba == BA_BASE
      && (cmd_q.addr & BASE_DLL_RESET_MASK) != '0;
  endsequence

  a_cke_powerup: assert property ($rose(cke_q) |-> up_q >= PWR_LEN)
    else $error("clock enable rose before the power-up wait");
  a_nop_first: assert property ($rose(cke_q) |-> s_nop_tick)
    else $error("no NOP held with the clock enable rise");
  a_pre_after: assert property ($rose(cke_q) |-> s_nop_tick ##1 cmd_q.op == OP_PRE)
    else $error("precharge all did not follow the first NOP");
  a_prech_gap: assert property (cmd_new_q && last_op_q == OP_PRE |-> gap_q >= TRP_LEN)
    else $error("command too soon after precharge");
  a_mode_gap: assert property (cmd_new_q && last_op_q == OP_LMR |-> gap_q >= MODE_REGISTER_SET_TIME_LEN)
    else $error("command too soon after mode load");
  a_emr_value: assert property (
    cmd_new_q && cmd_q.op == OP_LMR && cmd_q.ba == BA_EXT
      |-> (cmd_q.addr & ~EXT_DRIVE_STRENGTH_MASK) == '0
        && (cmd_q.addr & EXT_DLL_DISABLE_MASK) == '0)
    else $error("extended mode word not legal");
  a_dll_order: assert property (s_dll_load |-> emr_seen_q)
    else $error("base mode load before extended mode load");
  a_read_wait: assert property ($rose(read_ok_q) |-> dll_gap_q >= DLL_LEN)
    else $error("reads allowed too soon after dll reset");
  a_ref_gap: assert property (cmd_new_q && last_op_q == OP_REF |-> gap_q >= REFRESH_CYCLE_TIME_LEN)
    else $error("command too soon after auto refresh");
  a_two_refresh: assert property ($rose(done_q) |-> ref_cnt_q >= 2'h2)
    else $error("ready with fewer than two refreshes");
  a_cke_refresh: assert property (
    last_op_q == OP_REF && gap_q <= REFRESH_CYCLE_TIME_LEN |-> cke_q)
    else $error("clock enable dropped during refresh");
  a_refresh_spacing: assert property (
    done_q && !ctrl_q[CTRL_SMALL_DENSITY_BIT] |-> ref_gap_q <= WAIT_W'(REF_LARGE_CYC))
    else $error("refresh spacing exceeded");
  a_ack_pulse: assert property (ack_q |=> !ack_q)
    else $error("bus ack held past one cycle");
endmodule
`default_nettype wire

// ===== tb/dram_model.sv
// behavioural ddr memory that audits every command it samples
`timescale 1ns/1ps
`default_nettype none
module dram_model
  import ddr_init_pkg::*;
#(
  parameter int PWR_CK = 20
) (
  // memory pins
  input wire logic ck_in,
  input wire logic nrst_in,
  input wire logic cke_in,
  input wire dram_cmd_t cmd_in,
  // audit settings and results
  input wire logic [7:0] ref_lim_in,
  output logic [7:0] viol_out,
  output logic [3:0] step_out,
  output logic [12:0] ext_out,
  output logic [12:0] base_out,
  output logic rd_legal_out
);
  // ==========================================================================
  // least gaps in memory clocks, rounded up from the times
  localparam int CK_NS = CORE_PERIOD_PS * DRAM_CLK_DIV / 1000;
  localparam int RP_CK = (ROW_PRECHARGE_TIME_NS + CK_NS - 1) / CK_NS;
  localparam int RFC_CK = (REFRESH_CYCLE_TIME_NS + CK_NS - 1) / CK_NS;
  logic [7:0] gap_q, need_q, low_q, dll_q, rcnt_q, rwin_q;
  logic [3:0] op;
  logic [1:0] ba;
  logic [12:0] a;
  logic ok;
  logic act;
  assign op = cmd_in.op;
  // a selected nop is no command: only cs_n low with another op code counts
  assign act = !op[3] && op[2:0] != 3'h7;
  assign ba = cmd_in.ba;
  assign a = cmd_in.addr;
  assign rd_legal_out = dll_q >= 8'd200;
  // ==========================================================================
  // command expected at each step; deselect (cs_n high) counts as a nop
  always_comb begin
    case (step_out)
      4'h1, 4'h4: ok = op == OP_PRE && a[10];
      4'h2: ok = op == OP_LMR && ba == BA_EXT && !a[0] && a[12:2] == 11'h000;
      4'h3: ok = op == OP_LMR && ba == BA_BASE && a[8];
      4'h5, 4'h6: ok = op == OP_REF;
      4'h7: ok = op == OP_LMR && ba == BA_BASE && a == (base_out & ~BASE_DLL_RESET_MASK);
      default: ok = op == OP_REF || (op == OP_LMR && ba == BA_BASE);
    endcase
  end
  always_ff @(posedge ck_in or negedge nrst_in) begin
    if (!nrst_in) begin
      viol_out <= 8'h00;
      step_out <= 4'h0;
      {gap_q, need_q, low_q, dll_q, rcnt_q, rwin_q} <= '0;
      ext_out <= 13'h0000;
      base_out <= 13'h0000;
    end else begin
      gap_q <= (gap_q == 8'hff) ? gap_q : gap_q + 8'h01;
      dll_q <= (dll_q == 8'hff) ? dll_q : dll_q + 8'h01;
      rcnt_q <= (rcnt_q == 8'hff) ? rcnt_q : rcnt_q + 8'h01;
      if (!cke_in && low_q != 8'hff) begin
        low_q <= low_q + 8'h01;
      end
      if (rwin_q != 8'h00) begin
        rwin_q <= rwin_q - 8'h01;
      end
      if ((rwin_q != 8'h00 && !cke_in) || (step_out == 4'h8 && rcnt_q > ref_lim_in)) begin
        viol_out <= viol_out + 8'h01;
      end
      if (step_out == 4'h0 && cke_in) begin
        if (low_q < 8'(PWR_CK) || act) begin
          viol_out <= viol_out + 8'h01;
        end
        step_out <= 4'h1;
        gap_q <= 8'h01;
        need_q <= 8'h01;
      end else if (cke_in && act) begin
        if (!ok || gap_q < need_q) begin
          viol_out <= viol_out + 8'h01;
        end
        gap_q <= 8'h01;
        need_q <= (op == OP_REF) ? 8'(RFC_CK) : 8'(RP_CK);
        if (step_out != 4'h8) begin
          step_out <= step_out + 4'h1;
        end
        if (op == OP_REF) begin
          rcnt_q <= 8'h00;
          rwin_q <= 8'(RFC_CK);
        end
        if (op == OP_LMR && ba == BA_EXT) begin
          ext_out <= a;
        end
        if (op == OP_LMR && ba == BA_BASE && a[8]) begin
          base_out <= a;
          dll_q <= 8'h00;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the ddr power-up controller
`timescale 1ns/1ps
`default_nettype none
module testbench
  import ddr_init_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic ck_n;
  logic [20:0] snap;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] q, rdat;
  logic ack, ck, done, rd_ok, legal, cke;
  dram_cmd_t cmd;
  logic [7:0] viol;
  logic [7:0] lim = 8'd100;
  logic [3:0] step;
  logic [12:0] ext, base;
  int error_cnt = 0;
  int compares = 0;
  always #2.5 clk = ~clk;
  ddr_init_ctrl #(.POWERUP_WAIT_CYC(40), .REF_SMALL_CYC(200), .REF_LARGE_CYC(150)) DUT (
    .CORE_CLK_IN(clk), .NRST_IN(nrst), .CE_IN(ce),
    .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
    .WB_SEL_IN(4'hf), .WB_DAT_IN(dat), .WB_DAT_OUT(q), .WB_ACK_OUT(ack),
    .DRAM_CK_OUT(ck), .DRAM_CK_N_OUT(ck_n), .DRAM_CKE_OUT(cke), .DRAM_CMD_OUT(cmd),
    .INIT_DONE_OUT(done), .READ_OK_OUT(rd_ok));
  // 40 core cycles of power-up wait are 20 memory clocks
  dram_model #(.PWR_CK(20)) mem (
    .ck_in(ck), .nrst_in(nrst), .cke_in(cke), .cmd_in(cmd), .ref_lim_in(lim),
    .viol_out(viol), .step_out(step), .ext_out(ext), .base_out(base),
    .rd_legal_out(legal));
  // ==========================================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rdat = q;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk({31'h0, n < 50}, 32'h1);
  endtask
  // level 0 waits for done, 1 for read_ok high, 2 for read_ok low
  task automatic wait_lvl(input int which);
    int n;
    n = 0;
    while ((which == 0 ? done : (which == 1 ? rd_ok : !rd_ok)) !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, n < 3000}, 32'h1);
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // read permission may only show once the memory could take a read
  always @(posedge clk) begin
    if (ck === 1'b0 && rd_ok === 1'b1) begin
      chk({31'h0, legal}, 32'h1);
    end
    // the clock pair must stay complementary, frozen or running
    if (nrst === 1'b1) begin
      chk({31'h0, ck_n}, {31'h0, ~ck});
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    wb(1'b0, REG_CTRL_OFS, 32'h0);
    chk(rdat, {27'h0, CTRL_RESET});
    wb(1'b0, REG_MODE_OFS, 32'h0);
    chk(rdat, 32'h0);
    wb(1'b1, 8'h0c, 32'hffff);
    wb(1'b0, 8'h0c, 32'h0);
    chk(rdat, 32'h0);
    wb(1'b1, REG_MODE_OFS, 32'h0062);
    // start with reduced drive, final clear load and small density
    wb(1'b1, REG_CTRL_OFS, 32'h17);
    wait_lvl(0);
    chk({28'h0, step}, 32'h8);
    chk({19'h0, ext}, 32'h2);
    chk({19'h0, base}, 32'h0162);
    wb(1'b0, REG_STATUS_OFS, 32'h0);
    chk(rdat & 32'h1, 32'h1);
    wait_lvl(1);
    // relock as after a clock rate change
    wb(1'b1, REG_CTRL_OFS, 32'h1e);
    wait_lvl(2);
    wait_lvl(1);
    wb(1'b0, REG_STATUS_OFS, 32'h0);
    chk(rdat & 32'h3, 32'h3);
    // a low clock enable freezes the memory clock and the pins; odd span so a
    // free-running clock would show
    ce <= 1'b0;
    @(posedge clk);
    snap = {ck, cke, cmd};
    repeat (7) @(posedge clk);
    chk({11'h0, ck, cke, cmd}, {11'h0, snap});
    ce <= 1'b1;
    // larger density tightens the refresh spacing
    wb(1'b1, REG_CTRL_OFS, 32'h06);
    repeat (200) @(posedge clk);
    lim <= 8'd75;
    repeat (1500) @(posedge clk);
    wb(1'b0, REG_STATUS_OFS, 32'h0);
    // refreshes are taken promptly, so at most one may ever be owed
    chk({31'h0, rdat[7:4] <= 4'h1}, 32'h1);
    chk({24'h0, viol}, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
